// *** hdl/mbw_slave.v ***
// Modbus RTU slave handler for single-register write and register read frames
`include "mbw_defines.vh"
`default_nettype none

module mbw_slave (
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire [7:0] station_addr_i,
    input wire [7:0] rx_byte_i,
    input wire rx_valid_i,
    input wire rx_frame_end_i,
    output reg [7:0] tx_byte_o,
    output wire tx_valid_o,
    input wire tx_ready_i,
    output wire run_cmd_o,
    output reg wr_stb_o,
    output reg [15:0] wr_id_o,
    output reg [15:0] wr_data_o,
    output wire busy_o
);

    // Idle collects bytes, exec applies the request for one cycle, send drives the reply
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_EXEC = 3'b010;
    localparam [2:0] ST_SEND = 3'b100;

    // Bitwise CRC-16 step, reflected polynomial, one byte per call
    function [15:0] crc_upd;
        input [15:0] c;
        input [7:0] b;
        integer i;
        reg [15:0] x;
        begin
            x = c ^ {8'h00, b};
            for (i = 0; i < 8; i = i + 1) begin
                x = x[0] ? ((x >> 1) ^ `MBW_CRC_POLY) : (x >> 1);
            end
            crc_upd = x;
        end
    endfunction

    // Receive bookkeeping
    reg [2:0] state_q;
    reg [3:0] rx_cnt_q;
    reg [15:0] rx_crc_q;
    reg [7:0] rbuf [0:7];
    wire [15:0] hreg [0:`MBW_NREG-1];

    // Reply bookkeeping
    reg echo_q;
    reg [5:0] tx_len_q;
    reg [5:0] tx_cnt_q;
    reg [4:0] start_q;
    reg [15:0] tx_crc_q;
    reg [7:0] sel_byte;

    // Fields of the buffered request, big-endian on the wire
    wire [15:0] req_reg = {rbuf[2], rbuf[3]};
    wire [15:0] req_val = {rbuf[4], rbuf[5]};
    wire [16:0] req_end = {1'b0, req_reg} + {1'b0, req_val};
    wire is_bcast = (rbuf[0] == `MBW_BCAST_ADDR);
    // Residual of zero means the trailing CRC matched the frame
    wire frame_ok = (rx_cnt_q == `MBW_REQ_LEN) && (rx_crc_q == 16'h0000);
    // Own station or broadcast is accepted
    wire addr_ok = is_bcast || (rbuf[0] == station_addr_i);
    // Function decode
    wire is_wr = (rbuf[1] == `MBW_FC_WRITE);
    wire is_rd = (rbuf[1] == `MBW_FC_READ);
    wire wr_ok = (req_reg < `MBW_NREG_W);
    // A read asks for one to the limit of registers, all inside the bank
    wire rd_qty_ok = (req_val != 16'h0000) && (req_val <= `MBW_MAX_QTY);
    wire rd_span_ok = (req_end <= `MBW_NREG_W);
    wire rd_ok = rd_qty_ok && rd_span_ok;

    // Index arithmetic for the byte offered after the one now standing
    wire [5:0] nxt_idx = tx_cnt_q + 6'h01;
    wire [5:0] dat_idx = nxt_idx - 6'h03;
    wire [4:0] word_idx = start_q + {1'b0, dat_idx[4:1]};
    wire [15:0] word_sel = hreg[word_idx];
    // Running reply CRC including the byte now standing
    wire [15:0] crc_nx = crc_upd(tx_crc_q, tx_byte_o);
    wire [5:0] byte_cnt = tx_len_q - `MBW_RD_OVH;
    wire wr_go = (state_q == ST_EXEC) && is_wr && wr_ok;

    // Handshake and busy outputs decode the state register; the run command is the run bit of the control register
    assign tx_valid_o = (state_q == ST_SEND);
    assign busy_o = (state_q != ST_IDLE);
    assign run_cmd_o = hreg[`MBW_CTRL_IDX][`MBW_RUN_BIT];

    // Next byte of the reply; echo mode replays the request verbatim
    always @* begin
        sel_byte = 8'h00;
        if (echo_q) begin
            sel_byte = rbuf[nxt_idx[2:0]];
        end else if (nxt_idx == 6'h01) begin
            sel_byte = `MBW_FC_READ;
        end else if (nxt_idx == 6'h02) begin
            sel_byte = {2'b00, byte_cnt};
        end else if (nxt_idx == tx_len_q - 6'h02) begin
            sel_byte = crc_nx[7:0];
        end else if (nxt_idx == tx_len_q - 6'h01) begin
            sel_byte = tx_crc_q[15:8];
        end else begin
            sel_byte = dat_idx[0] ? word_sel[7:0] : word_sel[15:8];
        end
    end

    // Receive side only listens while idle, so the buffer is stable during a reply
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_cnt_q <= 4'h0;
            rx_crc_q <= `MBW_CRC_INIT;
        end else if (state_q == ST_IDLE) begin
            if (rx_frame_end_i) begin
                rx_cnt_q <= 4'h0;
                rx_crc_q <= `MBW_CRC_INIT;
            end else if (rx_valid_i) begin
                // Count saturates so an overlong frame can never look complete
                if (rx_cnt_q != `MBW_RX_SAT) begin
                    rx_cnt_q <= rx_cnt_q + 4'h1;
                end
                rx_crc_q <= crc_upd(rx_crc_q, rx_byte_i);
            end
        end
    end

    // Request buffer has no reset; the frame check gates every use of it
    always @(posedge sys_clk_i) begin
        if ((state_q == ST_IDLE) && !rx_frame_end_i && rx_valid_i &&
            (rx_cnt_q < `MBW_REQ_LEN)) begin
            rbuf[rx_cnt_q[2:0]] <= rx_byte_i;
        end
    end

    // One flop bank per holding register; only the addressed bank loads on a write
    genvar g;
    generate
        for (g = 0; g < `MBW_NREG; g = g + 1) begin : g_hreg
            localparam [4:0] IDX = g;
            reg [15:0] val_q;
            assign hreg[g] = val_q;
            always @(posedge sys_clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    val_q <= 16'h0000;
                end else if (wr_go && (req_reg[4:0] == IDX)) begin
                    val_q <= req_val;
                end
            end
        end
    endgenerate

    // Control path: frame acceptance, request execution and reply sequencing
    always @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= ST_IDLE;
            echo_q <= 1'b0;
            tx_len_q <= 6'h00;
            tx_cnt_q <= 6'h00;
            start_q <= 5'h00;
            tx_crc_q <= `MBW_CRC_INIT;
            tx_byte_o <= 8'h00;
            wr_stb_o <= 1'b0;
            wr_id_o <= 16'h0000;
            wr_data_o <= 16'h0000;
        end else begin
            // Write strobe is a single-cycle pulse by default
            wr_stb_o <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    // Frame is judged only on its end marker
                    if (rx_frame_end_i && frame_ok && addr_ok) begin
                        state_q <= ST_EXEC;
                    end
                end
                // Exec: one cycle in which the buffered request is applied
                ST_EXEC: begin
                    state_q <= ST_IDLE;
                    tx_cnt_q <= 6'h00;
                    tx_crc_q <= `MBW_CRC_INIT;
                    tx_byte_o <= rbuf[0];
                    // Broadcast writes land but leave the reply path silent
                    if (is_wr && wr_ok) begin
                        wr_stb_o <= 1'b1;
                        wr_id_o <= req_reg + `MBW_ID_OFS;
                        wr_data_o <= req_val;
                        if (!is_bcast) begin
                            echo_q <= 1'b1;
                            tx_len_q <= {2'b00, `MBW_REQ_LEN};
                            state_q <= ST_SEND;
                        end
                    // Reads never answer a broadcast; length is overhead plus two bytes a word
                    end else if (is_rd && rd_ok && !is_bcast) begin
                        echo_q <= 1'b0;
                        tx_len_q <= `MBW_RD_OVH + {req_val[4:0], 1'b0};
                        start_q <= req_reg[4:0];
                        state_q <= ST_SEND;
                    end
                end
                // Send: a byte is consumed on each edge with ready high
                ST_SEND: begin
                    if (tx_ready_i) begin
                        if (tx_cnt_q == tx_len_q - 6'h01) begin
                            state_q <= ST_IDLE;
                        end else begin
                            tx_cnt_q <= nxt_idx;
                            tx_byte_o <= sel_byte;
                            if (!echo_q && (nxt_idx < tx_len_q - 6'h01)) begin
                                tx_crc_q <= crc_nx;
                            end
                        end
                    end
                end
                // Any illegal state code falls back to idle
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// *** pkg/mbw_defines.vh ***
// Constants for the single-register write / register read slave handler
// Summary of operation
// - Function code 06 stores one 16-bit word into the addressed holding register.
// - Register address on the wire is the register ID minus one.
// - A successful write to the own station is answered with an exact copy of the request.
// - A broadcast write (station zero) is carried out as well.
// - Bit zero of the control word (ID 1) set commands the drive to run.
// - Function code 03 returns consecutive registers after a byte count of two each.
`ifndef MBW_DEFINES_VH
`define MBW_DEFINES_VH

`define MBW_FC_READ 8'h03
`define MBW_FC_WRITE 8'h06
`define MBW_BCAST_ADDR 8'h00
`define MBW_REQ_LEN 4'h8
`define MBW_RX_SAT 4'hf
`define MBW_NREG 32
`define MBW_NREG_W 17'h00020
`define MBW_MAX_QTY 16'h0010
`define MBW_ID_OFS 16'h0001
`define MBW_CTRL_IDX 0
`define MBW_RUN_BIT 0
`define MBW_RD_OVH 6'h05
`define MBW_CRC_INIT 16'hffff
`define MBW_CRC_POLY 16'ha001

`endif

// *** tb/mbw_master_model.sv ***
// Bus master model: sends request frames and collects reply bytes
`default_nettype none
module mbw_master_model (
    input wire logic clk_i,
    input wire logic slow_i,
    input wire logic [7:0] tx_byte_i,
    input wire logic tx_valid_i,
    output logic [7:0] rx_byte_o = 8'h00,
    output logic rx_valid_o = 1'b0,
    output logic rx_frame_end_o = 1'b0,
    output logic tx_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] reply_q[$];
    logic [1:0] cnt_q = 2'h0;
    assign tx_ready_o = !slow_i || cnt_q == 2'h3;
    always @(posedge clk_i) begin
        cnt_q <= cnt_q + 2'h1;
        if (tx_valid_i && tx_ready_o) reply_q.push_back(tx_byte_i);
    end
    task automatic send(input logic [7:0] f[$]);
        foreach (f[i]) begin
            @(posedge clk_i);
            rx_byte_o <= f[i];
            rx_valid_o <= 1'b1;
        end
        @(posedge clk_i);
        rx_byte_o <= ~rx_byte_o;
        rx_valid_o <= 1'b0;
        rx_frame_end_o <= 1'b1;
        @(posedge clk_i);
        rx_frame_end_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** tb/mbw_slave_assertions.sv ***
// Port checker for the write and read slave
`default_nettype none
module mbw_slave_assertions (
    input wire logic sys_clk_i, rst_b_i, rx_frame_end_i, tx_valid_o, tx_ready_i,
    input wire logic run_cmd_o, wr_stb_o, busy_o,
    input wire logic [7:0] tx_byte_o,
    input wire logic [15:0] wr_id_o, wr_data_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    a_stb_pulse: assert property (wr_stb_o |=> !wr_stb_o) else $error("long strobe");
    a_stb_busy: assert property (wr_stb_o |-> $past(busy_o)) else $error("idle write");
    a_id_range: assert property (wr_stb_o |-> wr_id_o inside {[1:32]}) else $error("id");
    a_id_hold: assert property (!wr_stb_o |-> $stable({wr_id_o, wr_data_o}))
        else $error("write moved");
    a_run_ctrl: assert property (wr_stb_o && wr_id_o == 16'h0001 |-> run_cmd_o == wr_data_o[0])
        else $error("run bit");
    a_run_hold: assert property ($changed(run_cmd_o) |-> wr_stb_o) else $error("run moved");
    a_tx_stand: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_byte_o))
        else $error("reply byte lost");
    a_tx_busy: assert property (tx_valid_o |-> busy_o) else $error("reply while idle");
    a_busy_end: assert property ($rose(busy_o) |-> $past(rx_frame_end_i)) else $error("busy");
endmodule
`default_nettype wire

// *** tb/mbw_slave_bench.sv ***
// Bench for the write and read slave
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module mbw_slave_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_b = 1'b0, slow = 1'b0, rv, re, tv, tr, run, stb, busy;
    logic [7:0] rb, tb, e[$], f[$];
    logic [15:0] wid, wdat;
    int fail_count = 0, total_checks = 0, cyc = 0, stbs = 0;
    mbw_slave i_mbw_slave (.sys_clk_i(clk), .rst_b_i(rst_b), .station_addr_i(8'h01),
        .rx_byte_i(rb), .rx_valid_i(rv), .rx_frame_end_i(re), .tx_byte_o(tb), .tx_valid_o(tv),
        .tx_ready_i(tr), .run_cmd_o(run), .wr_stb_o(stb), .wr_id_o(wid), .wr_data_o(wdat),
        .busy_o(busy));
    mbw_master_model i_mbw_master_model (.clk_i(clk), .slow_i(slow), .tx_byte_i(tb),
        .tx_valid_i(tv), .rx_byte_o(rb), .rx_valid_o(rv), .rx_frame_end_o(re), .tx_ready_o(tr));
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        stbs <= stbs + int'(stb === 1'b1);
        if (cyc == 20000) begin
            fail_count++;
            wrap_up();
        end
    end
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c = 16'hffff;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    task automatic xfer(input logic [7:0] s, fc, input logic [15:0] a, v, input logic bad,
        input int nstb, input logic echo);
        logic [15:0] c;
        int n0;
        f = {s, fc, a[15:8], a[7:0], v[15:8], v[7:0]};
        c = crc16(f) ^ {15'h0000, bad};
        f.push_back(c[7:0]);
        f.push_back(c[15:8]);
        if (echo) e = f;
        n0 = stbs;
        i_mbw_master_model.reply_q.delete();
        i_mbw_master_model.send(f);
        repeat (3) @(posedge clk);
        for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clk);
        @(posedge clk);
        `CHK(stbs - n0, nstb)
        `CHK(i_mbw_master_model.reply_q.size(), e.size())
        foreach (e[i]) `CHK(i_mbw_master_model.reply_q[i], e[i])
    endtask
    task automatic t_write_own();
        xfer(8'h01, 8'h06, 16'h0000, 16'h0001, 1'b0, 1, 1'b1);
        `CHK({wid, wdat, run}, {16'h0001, 16'h0001, 1'b1})
    endtask
    task automatic t_broadcast();
        e = {};
        xfer(8'h00, 8'h06, 16'h001f, 16'h1234, 1'b0, 1, 1'b0);
        `CHK({wid, wdat}, {16'h0020, 16'h1234})
    endtask
    task automatic t_read();
        logic [15:0] c;
        slow <= 1'b1;
        e = {8'h01, 8'h03, 8'h02, 8'h12, 8'h34};
        c = crc16(e);
        e = {e, c[7:0], c[15:8]};
        xfer(8'h01, 8'h03, 16'h001f, 16'h0001, 1'b0, 0, 1'b0);
        slow <= 1'b0;
    endtask
    task automatic t_reject();
        e = {};
        xfer(8'h01, 8'h06, 16'h0000, 16'h0000, 1'b1, 0, 1'b0);
        xfer(8'h07, 8'h06, 16'h0000, 16'h0000, 1'b0, 0, 1'b0);
        `CHK(run, 1'b1)
        xfer(8'h01, 8'h06, 16'h0000, 16'h0000, 1'b0, 1, 1'b1);
        `CHK(run, 1'b0)
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        t_write_own();
        t_broadcast();
        t_read();
        t_reject();
        wrap_up();
    end
endmodule
bind mbw_slave mbw_slave_assertions i_mbw_slave_assertions (.sys_clk_i, .rst_b_i,
    .rx_frame_end_i, .tx_valid_o, .tx_ready_i, .run_cmd_o, .wr_stb_o, .busy_o, .tx_byte_o,
    .wr_id_o, .wr_data_o);
`default_nettype wire
